// [inc/rcr_defines.vh]
// Constants for the reset cause recorder
`ifndef RCR_DEFINES_VH
`define RCR_DEFINES_VH

`define RCR_ADDR_W        4
`define RCR_OFF_FLAGS     4'h0
`define RCR_OFF_IRQ_STAT  4'h4
`define RCR_OFF_IRQ_MASK  4'h8
`define RCR_OFF_CTRL      4'hc

`define RCR_BIT_TRAP      15
`define RCR_BIT_IOP       14
`define RCR_BIT_CM        9
`define RCR_BIT_EXT       7
`define RCR_BIT_SW        6
`define RCR_BIT_WDT       4
`define RCR_BIT_SLEEP     3
`define RCR_BIT_IDLE      2
`define RCR_BIT_BOR       1
`define RCR_BIT_POR       0

`define RCR_FLAG_MASK     16'hc2df
`define RCR_FLAGS_RST     16'h0000
`define RCR_WREG_INIT     16'h0000
`define RCR_NUM_W         16
`define RCR_WIDX_W        4

`define RCR_IRQ_W         5
`define RCR_IRQ_RESET     0
`define RCR_IRQ_UNINIT    1
`define RCR_IRQ_SECURITY  2
`define RCR_IRQ_WDT       3
`define RCR_IRQ_POWERSAVE 4
`define RCR_IRQ_ZERO      5'h00

`define RCR_CTRL_WDT_EN   0

`endif

// [src/rcr_wreg_tracker.v]
// Working register array with uninitialised-use detection
`timescale 1ns/10ps
`include "rcr_defines.vh"
module rcr_wreg_tracker #(
   parameter NUM_W  = `RCR_NUM_W,
   parameter IDX_W  = `RCR_WIDX_W,
   parameter DATA_W = 16
) (
   input  wire              clk_i,      // System clock
   input  wire              clear_i,    // Any device reset
   input  wire              wr_en_i,    // Working register write
   input  wire [IDX_W-1:0]  wr_idx_i,   // Register written
   input  wire [DATA_W-1:0] wr_data_i,  // Write data
   input  wire              ptr_use_i,  // Register used as pointer
   input  wire [IDX_W-1:0]  ptr_idx_i,  // Pointer register index
   output reg  [DATA_W-1:0] ptr_data_o, // Pointer register value
   output reg               uninit_o    // Pulse: uninitialised pointer use
);
   reg [DATA_W-1:0] wreg_mem [0:NUM_W-1];
   reg [NUM_W-1:0]  valid_reg;
   integer          i;

   always @(posedge clk_i) begin
      if (clear_i) begin
         for (i = 0; i < NUM_W - 1; i = i + 1) begin
            wreg_mem[i] <= `RCR_WREG_INIT;
         end
         valid_reg                 <= {NUM_W{1'b0}};
         valid_reg[NUM_W-1]        <= 1'b1;
         uninit_o                  <= 1'b0;
         ptr_data_o                <= `RCR_WREG_INIT;
      end else begin
         if (wr_en_i) begin
            wreg_mem[wr_idx_i]  <= wr_data_i;
            valid_reg[wr_idx_i] <= 1'b1;
         end
         ptr_data_o <= wreg_mem[ptr_idx_i];
         uninit_o   <= ptr_use_i & ~valid_reg[ptr_idx_i];
      end
   end
endmodule

// [src/rcr_top.v]
// Reset cause recorder with Wishbone register access
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "rcr_defines.vh"
module rcr_top #(
   parameter IDX_W = `RCR_WIDX_W
) (
   input  wire             clk_i,          // System clock, 50 MHz
   input  wire             rst_i,          // Sync reset, active high
   input  wire             por_i,          // Power-on reset event
   input  wire             brownout_reset_i, // Brown-out reset event
   input  wire             master_clear_pin_n_i, // Master clear pin, active low
   input  wire             trap_conflict_i, // Trap conflict event
   input  wire             illegal_opcode_i, // Illegal opcode event
   input  wire             config_mismatch_i, // Configuration mismatch event
   input  wire             reset_instr_i,  // Reset instruction executed
   input  wire             wdt_timeout_i,  // Watchdog time-out event
   input  wire             pwrsave_sleep_i, // Power-save sleep instruction
   input  wire             pwrsave_idle_i, // Power-save idle instruction
   input  wire             clear_watchdog_instruction_i, // Clear-watchdog instr
   input  wire             watchdog_config_fuse_i, // Watchdog fuse, 1 = unprogrammed
   input  wire             program_flow_change_i, // PC reloaded by branch type
   input  wire             vector_flow_change_i, // PC loaded with vector
   input  wire             target_restricted_i, // Flow target is restricted
   input  wire             wr_en_i,        // Working register write
   input  wire [IDX_W-1:0] wr_idx_i,       // Working register index
   input  wire [15:0]      wr_data_i,      // Working register data
   input  wire             ptr_use_i,      // Register used as pointer
   input  wire [IDX_W-1:0] ptr_idx_i,      // Pointer register index
   input  wire             wb_cyc_i,       // Wishbone cycle
   input  wire             wb_stb_i,       // Wishbone strobe
   input  wire             wb_we_i,        // Wishbone write enable
   input  wire [3:0]       wb_adr_i,       // Wishbone byte address
   input  wire [3:0]       wb_sel_i,       // Wishbone byte selects
   input  wire [31:0]      wb_dat_i,       // Wishbone write data
   output reg  [31:0]      wb_dat_o,       // Wishbone read data
   output reg              wb_ack_o,       // Wishbone acknowledge
   output reg              device_reset_o, // Device reset request pulse
   output reg              wdt_enable_o,   // Watchdog effective enable
   output reg  [15:0]      ptr_data_o,     // Pointer register value
   output reg              irq_o           // Interrupt, level
);
   reg  [15:0]            flags_reg;
   reg  [15:0]            flags_next;
   reg  [`RCR_IRQ_W-1:0]  irq_stat_reg;
   reg  [`RCR_IRQ_W-1:0]  irq_stat_next;
   reg  [`RCR_IRQ_W-1:0]  irq_mask_reg;
   reg                    sw_wdt_en_reg;
   reg  [1:0]             master_clear_pin_sync_reg;
   reg                    master_clear_pin_prev_reg;
   reg                    rst_pulse_reg;
   wire                   uninit;
   wire [15:0]            ptr_data;
   wire                   security;
   wire                   master_clear_pin_event;
   wire                   any_reset;
   wire                   bus_req;
   wire                   bus_wr;
   wire                   cause_reset;
   wire [15:0]            hw_set;
   wire [15:0]            hw_clr;
   wire [`RCR_IRQ_W-1:0]  irq_events;

   function [15:0] bit16;
      input integer pos;
      begin
         bit16      = 16'h0000;
         bit16[pos] = 1'b1;
      end
   endfunction

   // Pin passes two flops before use
   always @(posedge clk_i) begin
      master_clear_pin_sync_reg <= {master_clear_pin_sync_reg[0], ~master_clear_pin_n_i};
      master_clear_pin_prev_reg <= master_clear_pin_sync_reg[1];
   end
   assign master_clear_pin_event = master_clear_pin_sync_reg[1] & ~master_clear_pin_prev_reg;

   assign security = (program_flow_change_i | vector_flow_change_i) & target_restricted_i;

   assign cause_reset = uninit | security | illegal_opcode_i | trap_conflict_i |
                        config_mismatch_i | reset_instr_i | wdt_timeout_i | master_clear_pin_event;
   assign any_reset   = cause_reset | por_i | brownout_reset_i | rst_i;

   rcr_wreg_tracker #(
      .NUM_W  (`RCR_NUM_W),
      .IDX_W  (IDX_W),
      .DATA_W (16)
   ) u_wreg (
      .clk_i      (clk_i),
      .clear_i    (any_reset | rst_pulse_reg),
      .wr_en_i    (wr_en_i),
      .wr_idx_i   (wr_idx_i),
      .wr_data_i  (wr_data_i),
      .ptr_use_i  (ptr_use_i),
      .ptr_idx_i  (ptr_idx_i),
      .ptr_data_o (ptr_data),
      .uninit_o   (uninit)
   );

   assign hw_set = ({16{trap_conflict_i}}   & bit16(`RCR_BIT_TRAP))  |
                   ({16{illegal_opcode_i | uninit | security}} & bit16(`RCR_BIT_IOP)) |
                   ({16{config_mismatch_i}} & bit16(`RCR_BIT_CM))    |
                   ({16{master_clear_pin_event}}        & bit16(`RCR_BIT_EXT))   |
                   ({16{reset_instr_i}}     & bit16(`RCR_BIT_SW))    |
                   ({16{wdt_timeout_i}}     & bit16(`RCR_BIT_WDT))   |
                   ({16{pwrsave_sleep_i}}   & bit16(`RCR_BIT_SLEEP)) |
                   ({16{pwrsave_idle_i}}    & bit16(`RCR_BIT_IDLE))  |
                   ({16{por_i | brownout_reset_i}} & bit16(`RCR_BIT_BOR)) |
                   ({16{por_i}}             & bit16(`RCR_BIT_POR));

   assign hw_clr = ({16{por_i | brownout_reset_i}} &
                    ~(bit16(`RCR_BIT_EXT) | bit16(`RCR_BIT_BOR) | bit16(`RCR_BIT_POR))) |
                   ({16{por_i}} & bit16(`RCR_BIT_EXT)) |
                   ({16{pwrsave_sleep_i | pwrsave_idle_i | clear_watchdog_instruction_i}} &
                    bit16(`RCR_BIT_WDT));

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr  = bus_req & wb_we_i;

   always @* begin
      flags_next = flags_reg;
      if (bus_wr && wb_adr_i == `RCR_OFF_FLAGS) begin
         if (wb_sel_i[0]) begin
            flags_next[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            flags_next[15:8] = wb_dat_i[15:8];
         end
      end
      flags_next = flags_next & ~hw_clr;
      flags_next = (flags_next | hw_set) & `RCR_FLAG_MASK;
   end

   assign irq_events = {pwrsave_sleep_i | pwrsave_idle_i, wdt_timeout_i, security,
                        uninit, cause_reset};

   always @* begin
      irq_stat_next = irq_stat_reg;
      if (bus_wr && wb_adr_i == `RCR_OFF_IRQ_STAT && wb_sel_i[0]) begin
         irq_stat_next = irq_stat_reg & ~wb_dat_i[`RCR_IRQ_W-1:0];
      end
      irq_stat_next = irq_stat_next | irq_events;
   end

   // Flags survive rst_i; only por_i reloads them, events and bus writes go through flags_next
   always @(posedge clk_i) begin
      if (por_i) begin
         flags_reg <= `RCR_FLAGS_RST | bit16(`RCR_BIT_POR) | bit16(`RCR_BIT_BOR);
      end else begin
         flags_reg <= flags_next;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg   <= `RCR_IRQ_ZERO;
         irq_mask_reg   <= `RCR_IRQ_ZERO;
         sw_wdt_en_reg  <= 1'b0;
         wb_ack_o       <= 1'b0;
         wb_dat_o       <= 32'h00000000;
         device_reset_o <= 1'b0;
         wdt_enable_o   <= 1'b0;
         ptr_data_o     <= 16'h0000;
         irq_o          <= 1'b0;
         rst_pulse_reg  <= 1'b1;
      end else begin
         rst_pulse_reg  <= 1'b0;
         irq_stat_reg   <= irq_stat_next;
         wb_ack_o       <= bus_req;
         device_reset_o <= cause_reset | por_i | brownout_reset_i;
         wdt_enable_o   <= watchdog_config_fuse_i | sw_wdt_en_reg;
         ptr_data_o     <= ptr_data;
         irq_o          <= |(irq_stat_next & irq_mask_reg);
         if (bus_wr && wb_sel_i[0]) begin
            if (wb_adr_i == `RCR_OFF_IRQ_MASK) begin
               irq_mask_reg <= wb_dat_i[`RCR_IRQ_W-1:0];
            end else if (wb_adr_i == `RCR_OFF_CTRL) begin
               sw_wdt_en_reg <= wb_dat_i[`RCR_CTRL_WDT_EN];
            end
         end
         if (bus_req && !wb_we_i) begin
            if (wb_adr_i == `RCR_OFF_FLAGS) begin
               wb_dat_o <= {16'h0000, flags_reg};
            end else if (wb_adr_i == `RCR_OFF_IRQ_STAT) begin
               wb_dat_o <= {27'h0000000, irq_stat_reg};
            end else if (wb_adr_i == `RCR_OFF_IRQ_MASK) begin
               wb_dat_o <= {27'h0000000, irq_mask_reg};
            end else if (wb_adr_i == `RCR_OFF_CTRL) begin
               wb_dat_o <= {31'h00000000, sw_wdt_en_reg};
            end else begin
               wb_dat_o <= 32'h00000000;
            end
         end
      end
   end
endmodule

// [sim/rcr_top_properties.sv]
// Assertion checker for the reset cause recorder
`timescale 1ns/10ps
module rcr_top_properties (
   input wire        clk_i,                  // Clock
   input wire        rst_i,                  // Reset
   input wire        master_clear_pin_n_i,   // Pin
   input wire        illegal_opcode_i,       // Event
   input wire        wdt_timeout_i,          // Event
   input wire        watchdog_config_fuse_i, // Fuse
   input wire        program_flow_change_i,  // Flow
   input wire        vector_flow_change_i,   // Vector
   input wire        target_restricted_i,    // Restricted
   input wire        wb_cyc_i,               // Cycle
   input wire        wb_stb_i,               // Strobe
   input wire        wb_we_i,                // Write
   input wire [3:0]  wb_adr_i,               // Address
   input wire [31:0] wb_dat_o,               // Read data
   input wire        wb_ack_o,               // Ack
   input wire        device_reset_o,         // Reset out
   input wire        wdt_enable_o,           // Watchdog on
   input wire        irq_o                   // Interrupt
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   chk_wdt_reset: assert property (wdt_timeout_i |=> device_reset_o)
      else $error("no watchdog reset");
   chk_opcode_reset: assert property (illegal_opcode_i |=> device_reset_o)
      else $error("no opcode reset");
   chk_flow_reset: assert property (program_flow_change_i && target_restricted_i
      |-> ##[1:3] device_reset_o)
      else $error("no flow security reset");
   chk_vector_reset: assert property (vector_flow_change_i && target_restricted_i
      |-> ##[1:3] device_reset_o)
      else $error("no vector security reset");
   chk_pin_reset: assert property ($fell(master_clear_pin_n_i) |-> ##[1:5] device_reset_o)
      else $error("no pin reset");
   chk_fuse_forces: assert property (watchdog_config_fuse_i |=> wdt_enable_o)
      else $error("fuse ignored");
   chk_flags_unused: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0
      |-> (wb_dat_o & 32'hffff3d20) == 32'h0)
      else $error("unused flag bits set");
   cover property (wdt_timeout_i ##1 device_reset_o);
   cover property (wb_ack_o && wb_we_i);
   cover property ($rose(irq_o));
endmodule
bind rcr_top rcr_top_properties i_props (.clk_i, .rst_i, .master_clear_pin_n_i,
   .illegal_opcode_i, .wdt_timeout_i, .watchdog_config_fuse_i, .program_flow_change_i,
   .vector_flow_change_i, .target_restricted_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .device_reset_o, .wdt_enable_o, .irq_o);

// [sim/testbench.sv]
// Self-checking bench for the reset cause recorder
`timescale 1ns/10ps
module testbench;
   logic clk_i = 0, rst_i = 1, por_i = 0, bor_i = 0, pin_n = 1, fuse = 0;
   logic program_flow_change = 0, vector_flow_change = 0, restr = 0, wr_en = 0, ptr_use = 0;
   logic [7:0] ev = 8'h00;
   logic [3:0] wr_idx = 4'h0, ptr_idx = 4'h0, adr = 4'h0, sel = 4'h0;
   logic [15:0] wr_data = 16'h0000;
   logic cyc = 0, stb = 0, we = 0;
   logic [31:0] wdat = 32'h0, d;
   wire [31:0] rdat;
   wire [15:0] ptr_data;
   wire ack, dev_rst, wdt_en, irq;
   integer failures = 0, checks = 0, resets = 0, cycles = 0, r0, i;
   localparam logic [15:0] EXP [8] = '{16'h8010, 16'h4010, 16'h0210, 16'h0050,
                                       16'h0010, 16'h0008, 16'h0004, 16'h0000};
   localparam logic [2:0] SEC [3] = '{3'b101, 3'b011, 3'b100};
   always #10 clk_i = ~clk_i;
   rcr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .brownout_reset_i(bor_i),
      .master_clear_pin_n_i(pin_n), .trap_conflict_i(ev[0]), .illegal_opcode_i(ev[1]),
      .config_mismatch_i(ev[2]), .reset_instr_i(ev[3]), .wdt_timeout_i(ev[4]),
      .pwrsave_sleep_i(ev[5]), .pwrsave_idle_i(ev[6]), .clear_watchdog_instruction_i(ev[7]),
      .watchdog_config_fuse_i(fuse), .program_flow_change_i(program_flow_change), .vector_flow_change_i(vector_flow_change),
      .target_restricted_i(restr), .wr_en_i(wr_en), .wr_idx_i(wr_idx), .wr_data_i(wr_data),
      .ptr_use_i(ptr_use), .ptr_idx_i(ptr_idx), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .device_reset_o(dev_rst), .wdt_enable_o(wdt_en), .ptr_data_o(ptr_data), .irq_o(irq));
   task final_report;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (dev_rst === 1'b1) resets <= resets + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         final_report;
      end
   end
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task xfer(input logic w, input logic [3:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, wd, 4'hf};
      do @(posedge clk_i); while (ack !== 1'b1);
      d = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task flags(input logic [15:0] exp);
      xfer(0, 4'h0, 0);
      check("flags", d, {16'h0, exp});
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   task ptr(input logic [3:0] x);
      @(posedge clk_i) {ptr_use, ptr_idx} <= {1'b1, x};
      @(posedge clk_i) ptr_use <= 0;
      tick(3);
   endtask
   initial begin
      tick(4);
      rst_i <= 0;
      @(posedge clk_i) por_i <= 1;
      @(posedge clk_i) por_i <= 0;
      tick(2);
      flags(16'h0003);
      for (i = 0; i < 8; i++) begin
         xfer(1, 4'h0, 32'h10);
         r0 = resets;
         @(posedge clk_i) ev[i] <= 1;
         @(posedge clk_i) ev[i] <= 0;
         tick(2);
         flags(EXP[i]);
         check("resets", resets - r0, i < 5);
      end
      xfer(1, 4'h0, 0);
      @(posedge clk_i) pin_n <= 0;
      tick(3);
      pin_n <= 1;
      tick(5);
      flags(16'h0080);
      r0 = resets;
      xfer(1, 4'h0, 32'hc2df);
      tick(2);
      check("sw set resets", resets - r0, 0);
      @(posedge clk_i) bor_i <= 1;
      @(posedge clk_i) bor_i <= 0;
      tick(2);
      flags(16'h0083);
      @(posedge clk_i) rst_i <= 1;
      @(posedge clk_i) rst_i <= 0;
      flags(16'h0083);
      xfer(1, 4'h0, 0);
      r0 = resets;
      ptr(4'h3);
      ptr(4'hf);
      flags(16'h4000);
      check("uninit resets", resets - r0, 1);
      @(posedge clk_i) {wr_en, wr_idx, wr_data} <= {1'b1, 4'h3, 16'ha5c3};
      @(posedge clk_i) wr_en <= 0;
      r0 = resets;
      ptr(4'h3);
      check("ptr data", ptr_data, 16'ha5c3);
      check("written resets", resets - r0, 0);
      for (i = 0; i < 3; i++) begin
         xfer(1, 4'h0, 0);
         r0 = resets;
         @(posedge clk_i) {program_flow_change, vector_flow_change, restr} <= SEC[i];
         @(posedge clk_i) {program_flow_change, vector_flow_change, restr} <= 3'b000;
         tick(3);
         flags(i < 2 ? 16'h4000 : 16'h0000);
         check("security resets", resets - r0, i < 2);
      end
      fork
         xfer(1, 4'h0, 0);
         begin
            tick(1);
            ev[1] <= 1;
            @(posedge clk_i) ev[1] <= 0;
         end
      join
      flags(16'h4000);
      xfer(1, 4'h4, 32'h1f);
      xfer(1, 4'h8, 32'h08);
      @(posedge clk_i) ev[4] <= 1;
      @(posedge clk_i) ev[4] <= 0;
      tick(2);
      check("irq", irq, 1);
      xfer(0, 4'h4, 0);
      check("irq status", d, 32'h09);
      xfer(1, 4'h8, 0);
      tick(2);
      check("irq masked", irq, 0);
      xfer(1, 4'h8, 32'h08);
      tick(2);
      check("irq unmasked", irq, 1);
      xfer(1, 4'h4, 32'h08);
      tick(2);
      check("irq cleared", irq, 0);
      fuse <= 1;
      xfer(1, 4'hc, 0);
      check("wdt fuse", wdt_en, 1);
      fuse <= 0;
      tick(2);
      check("wdt off", wdt_en, 0);
      xfer(1, 4'hc, 1);
      tick(2);
      check("wdt sw", wdt_en, 1);
      xfer(1, 4'h2, 32'hffff);
      xfer(0, 4'h2, 0);
      check("unmapped", d, 0);
      final_report;
   end
endmodule
